// >>> lpm_ctrl.sv
// Low-power mode controller: mode sequencer, domain gating and register slave
`default_nettype none
module lpm_ctrl #(
  parameter int IRQ_W = 8,
  parameter int CNT_W = 8,
  parameter int OSC_CYC = lpm_pkg::OSC_CYC,
  parameter int PLL_CYC = lpm_pkg::PLL_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Processor and interrupt side
  input wire logic wait_exec_i,
  input wire logic [IRQ_W-1:0] irq_i,
  input wire logic poe_irq_i,
  output logic wake_int_o,
  output logic wake_reset_o,
  output logic poe_irq_o,
  // Domain controls
  output lpm_pkg::lpm_dom_t dom_o,
  output logic io_hold_o
);
  localparam int RESUME_MAX = 600;

  lpm_pkg::lpm_state_t state, next_state;
  lpm_pkg::lpm_mode_t mode_q, next_mode;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_wint, next_wrst;
  logic poe_pend, next_poe_pend;
  lpm_pkg::lpm_dom_t next_dom;
  logic next_io_hold;
  lpm_pkg::lpm_ctrl_t ctrl;
  logic [IRQ_W-1:0] wmask;
  logic poe_clr;
  lpm_pkg::lpm_stat_t stat;
  logic wake;

  assign stat = '{poe_pend: poe_pend, mode: mode_q, state: state};
  assign wake = |(irq_i & wmask);

  lpm_regs #(
    .IRQ_W(IRQ_W)
  ) u_regs (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .stat_i(stat),
    .ctrl_o(ctrl),
    .wmask_o(wmask),
    .poe_clr_o(poe_clr)
  );

  // ********************************
  // Mode sequencer
  // ********************************
  always_comb begin
    next_state = state;
    next_mode = mode_q;
    next_cnt = cnt;
    next_wint = 1'b0;
    next_wrst = 1'b0;
    case (state)
      lpm_pkg::ST_RUN: begin
        if (wait_exec_i && ctrl.mode != lpm_pkg::MODE_NONE) begin
          next_state = lpm_pkg::ST_GATE;
          next_mode = ctrl.mode;
        end
      end
      lpm_pkg::ST_GATE: next_state = lpm_pkg::ST_SLEEP;
      lpm_pkg::ST_SLEEP: begin
        if (wake) begin
          next_state = lpm_pkg::ST_WOSC;
          next_cnt = CNT_W'(OSC_CYC - 1);
        end
      end
      lpm_pkg::ST_WOSC: begin
        if (cnt == '0) begin
          next_state = lpm_pkg::ST_WPLL;
          next_cnt = CNT_W'(PLL_CYC - 1);
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      lpm_pkg::ST_WPLL: begin
        if (cnt == '0) begin
          next_state = lpm_pkg::ST_RESUME;
          next_wint = (mode_q != lpm_pkg::MODE_DEEP);
          next_wrst = (mode_q == lpm_pkg::MODE_DEEP);
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      lpm_pkg::ST_RESUME: next_state = lpm_pkg::ST_RUN;
      default: next_state = lpm_pkg::ST_RUN;
    endcase
  end

  // ********************************
  // Domain gating
  // ********************************
  always_comb begin
    logic low;
    logic sleep;
    logic stby;
    logic deep;
    logic cstp;
    low = next_state inside {lpm_pkg::ST_GATE, lpm_pkg::ST_SLEEP,
        lpm_pkg::ST_WOSC, lpm_pkg::ST_WPLL};
    sleep = (next_state == lpm_pkg::ST_SLEEP);
    deep = (next_mode == lpm_pkg::MODE_DEEP);
    cstp = (next_mode == lpm_pkg::MODE_CSTP);
    stby = (next_mode == lpm_pkg::MODE_SSBY) || deep;
    next_io_hold = low;
    // crystals follow control, internal sources stop in standby sleep
    next_dom.main_osc = ctrl.main_osc;
    next_dom.sub_osc = ctrl.sub_osc;
    next_dom.hoco = ctrl.hoco && !(sleep && stby);
    next_dom.loco = ctrl.loco && !(sleep && stby);
    // PLLs come back after oscillators settle
    next_dom.pll = ctrl.pll && !((sleep || next_state == lpm_pkg::ST_WOSC) && stby);
    next_dom.peripheral_pll = ctrl.peripheral_pll && !((sleep || next_state == lpm_pkg::ST_WOSC) && stby);
    next_dom.cpu_clk = !low;
    next_dom.periph_clk = !low;
    next_dom.ram_clk = !low;
    next_dom.ram_pwr_off = sleep && deep;
    next_dom.periph_pwr_off = sleep && deep;
    next_dom.independent_watchdog_osc = ctrl.independent_watchdog && !(low && deep);
    next_dom.independent_watchdog_clk = ctrl.independent_watchdog && !(low && deep);
    next_dom.independent_watchdog_pwr_off = sleep && deep;
    next_dom.tmr_clk = ctrl.tmr && !(low && !cstp);
    next_dom.tmr_pwr_off = sleep && deep;
    next_dom.poe_clk = ctrl.port_output_disable_unit && !(low && !cstp);
    next_dom.poe_pwr_off = sleep && deep;
    next_dom.rtc_en = ctrl.rtc;
    next_dom.lvd_en = ctrl.voltage_monitor;
    next_dom.por_en = 1'b1;
    next_dom.usb_clk = ctrl.usb && !low;
    next_dom.usb_pwr_off = sleep && deep && !ctrl.usb_keep;
  end

  // ********************************
  // Port output disable pending flag
  // ********************************
  always_comb begin
    next_poe_pend = (poe_irq_i && ctrl.port_output_disable_unit) || (poe_pend && !poe_clr);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= lpm_pkg::ST_RUN;
      mode_q <= lpm_pkg::MODE_NONE;
      cnt <= '0;
      wake_int_o <= 1'b0;
      wake_reset_o <= 1'b0;
      poe_pend <= 1'b0;
      poe_irq_o <= 1'b0;
      dom_o <= '0;
      io_hold_o <= 1'b0;
    end else begin
      state <= next_state;
      mode_q <= next_mode;
      cnt <= next_cnt;
      wake_int_o <= next_wint;
      wake_reset_o <= next_wrst;
      poe_pend <= next_poe_pend;
      poe_irq_o <= next_poe_pend && (next_state == lpm_pkg::ST_RUN
          || next_state == lpm_pkg::ST_RESUME);
      dom_o <= next_dom;
      io_hold_o <= next_io_hold;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  sequence s_enter;
    state == lpm_pkg::ST_RUN && wait_exec_i && ctrl.mode != lpm_pkg::MODE_NONE;
  endsequence
  sequence s_gate_then_sleep;
    state == lpm_pkg::ST_GATE && !dom_o.cpu_clk ##1 state == lpm_pkg::ST_SLEEP;
  endsequence
  sequence s_wake_seen;
    state == lpm_pkg::ST_SLEEP && wake;
  endsequence

  property p_enter;
    @(posedge mclk_i) disable iff (rst_i)
    s_enter |=> s_gate_then_sleep;
  endproperty
  a_enter: assert property (p_enter) else $error("wait did not gate then sleep");

  property p_resume;
    @(posedge mclk_i) disable iff (rst_i)
    s_wake_seen |=> state == lpm_pkg::ST_WOSC ##[1:RESUME_MAX]
        (wake_int_o != wake_reset_o) && (wake_reset_o == (mode_q == lpm_pkg::MODE_DEEP));
  endproperty
  a_resume: assert property (p_resume) else $error("wake did not resume correctly");

  property p_stby_osc;
    @(posedge mclk_i) disable iff (rst_i)
    state == lpm_pkg::ST_SLEEP && mode_q inside {lpm_pkg::MODE_SSBY, lpm_pkg::MODE_DEEP}
        |-> !dom_o.hoco && !dom_o.loco && !dom_o.pll && !dom_o.peripheral_pll;
  endproperty
  a_stby_osc: assert property (p_stby_osc) else $error("internal clock left on");

  property p_ram;
    @(posedge mclk_i) disable iff (rst_i)
    state == lpm_pkg::ST_SLEEP |-> !dom_o.ram_clk
        && (dom_o.ram_pwr_off == (mode_q == lpm_pkg::MODE_DEEP));
  endproperty
  a_ram: assert property (p_ram) else $error("memory retention wrong");

  property p_independent_watchdog;
    @(posedge mclk_i) disable iff (rst_i)
    state == lpm_pkg::ST_SLEEP && mode_q == lpm_pkg::MODE_DEEP
        |-> !dom_o.independent_watchdog_osc && !dom_o.independent_watchdog_clk && dom_o.independent_watchdog_pwr_off;
  endproperty
  a_independent_watchdog: assert property (p_independent_watchdog) else $error("watchdog alive in deep standby");

  property p_tmr_poe;
    @(posedge mclk_i) disable iff (rst_i)
    state == lpm_pkg::ST_SLEEP && mode_q == lpm_pkg::MODE_SSBY
        |-> !dom_o.tmr_clk && !dom_o.poe_clk && !dom_o.tmr_pwr_off && !dom_o.poe_pwr_off;
  endproperty
  a_tmr_poe: assert property (p_tmr_poe) else $error("timer or poe not frozen");

  property p_monitors;
    @(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> dom_o.lvd_en == $past(ctrl.voltage_monitor) && dom_o.rtc_en == $past(ctrl.rtc) && dom_o.por_en;
  endproperty
  a_monitors: assert property (p_monitors) else $error("monitor not under control");

  property p_usb;
    @(posedge mclk_i) disable iff (rst_i)
    state == lpm_pkg::ST_SLEEP |-> !dom_o.usb_clk && io_hold_o;
  endproperty
  a_usb: assert property (p_usb) else $error("usb running or ports free");

  property p_poe_nowake;
    @(posedge mclk_i) disable iff (rst_i)
    state == lpm_pkg::ST_SLEEP && !wake && poe_irq_i && ctrl.port_output_disable_unit
        |=> state == lpm_pkg::ST_SLEEP && poe_pend && !poe_irq_o;
  endproperty
  a_poe_nowake: assert property (p_poe_nowake) else $error("poe woke the device");

  property p_order;
    @(posedge mclk_i) disable iff (rst_i)
    state == lpm_pkg::ST_WOSC && mode_q == lpm_pkg::MODE_SSBY
        |-> !dom_o.pll && !dom_o.cpu_clk && dom_o.hoco == $past(ctrl.hoco);
  endproperty
  a_order: assert property (p_order) else $error("restore order wrong");

  property p_retain;
    @(posedge mclk_i) disable iff (rst_i)
    $rose(state == lpm_pkg::ST_GATE) |-> !dom_o.periph_clk && !dom_o.periph_pwr_off;
  endproperty
  a_retain: assert property (p_retain) else $error("peripherals not frozen");
endmodule : lpm_ctrl
`default_nettype wire

// >>> lpm_pkg.sv
// Constants, register layout and types of the low-power mode controller
`default_nettype none
package lpm_pkg;
  // ********************************
  // Mode and state encodings
  // ********************************
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_CSTP = 2'h1,
    MODE_SSBY = 2'h2,
    MODE_DEEP = 2'h3
  } lpm_mode_t;

  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_GATE = 6'h02,
    ST_SLEEP = 6'h04,
    ST_WOSC = 6'h08,
    ST_WPLL = 6'h10,
    ST_RESUME = 6'h20
  } lpm_state_t;

  // ********************************
  // Register layout
  // ********************************
  typedef struct packed {
    logic usb_keep;
    logic usb;
    logic port_output_disable_unit;
    logic tmr;
    logic independent_watchdog;
    logic rtc;
    logic voltage_monitor;
    logic peripheral_pll;
    logic pll;
    logic loco;
    logic hoco;
    logic sub_osc;
    logic main_osc;
    lpm_mode_t mode;
  } lpm_ctrl_t;

  typedef struct packed {
    logic poe_pend;
    lpm_mode_t mode;
    lpm_state_t state;
  } lpm_stat_t;

  // Clock enables and power-off controls of each domain
  typedef struct packed {
    logic main_osc;
    logic sub_osc;
    logic hoco;
    logic loco;
    logic independent_watchdog_osc;
    logic pll;
    logic peripheral_pll;
    logic cpu_clk;
    logic ram_clk;
    logic periph_clk;
    logic usb_clk;
    logic tmr_clk;
    logic poe_clk;
    logic independent_watchdog_clk;
    logic rtc_en;
    logic lvd_en;
    logic por_en;
    logic ram_pwr_off;
    logic periph_pwr_off;
    logic usb_pwr_off;
    logic tmr_pwr_off;
    logic poe_pwr_off;
    logic independent_watchdog_pwr_off;
  } lpm_dom_t;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_WMASK = 4'h8;
  localparam int STAT_POE_BIT = 8;
  localparam logic [14:0] CTRL_RST = 15'h0030;
  localparam logic [31:0] WMASK_RST = 32'h00000000;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int OSC_SETTLE_NS = 200;
  localparam int PLL_SETTLE_NS = 400;
  localparam int OSC_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_CYC = (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : lpm_pkg
`default_nettype wire

// >>> lpm_regs.sv
// Avalon-MM register slave of the low-power mode controller
`default_nettype none
module lpm_regs #(
  parameter int IRQ_W = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Block side
  input wire lpm_pkg::lpm_stat_t stat_i,
  output lpm_pkg::lpm_ctrl_t ctrl_o,
  output logic [IRQ_W-1:0] wmask_o,
  output logic poe_clr_o
);
  localparam int CTRL_W = $bits(lpm_pkg::lpm_ctrl_t);
  localparam int STAT_W = $bits(lpm_pkg::lpm_stat_t);

  logic next_wait;
  logic [31:0] next_rdata;
  lpm_pkg::lpm_ctrl_t next_ctrl;
  logic [IRQ_W-1:0] next_wmask;
  logic next_clr;
  logic [31:0] be_mask;
  logic [31:0] rd_mux;

  // ********************************
  // Byte lane mask
  // ********************************
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign be_mask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
    end
  endgenerate

  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address_i)
      lpm_pkg::REG_CTRL: rd_mux[CTRL_W-1:0] = ctrl_o;
      lpm_pkg::REG_STAT: rd_mux[STAT_W-1:0] = stat_i;
      lpm_pkg::REG_WMASK: rd_mux[IRQ_W-1:0] = wmask_o;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ********************************
  // Access sequencing
  // ********************************
  always_comb begin
    next_wait = 1'b1;
    next_rdata = avs_readdata_o;
    next_ctrl = ctrl_o;
    next_wmask = wmask_o;
    next_clr = 1'b0;
    if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      next_wait = 1'b0;
      if (avs_read_i) begin
        next_rdata = rd_mux;
      end
    end
    if (avs_write_i && !avs_waitrequest_o) begin
      case (avs_address_i)
        lpm_pkg::REG_CTRL: next_ctrl = lpm_pkg::lpm_ctrl_t'(
            (rd_mux[CTRL_W-1:0] & ~be_mask[CTRL_W-1:0])
            | (avs_writedata_i[CTRL_W-1:0] & be_mask[CTRL_W-1:0]));
        lpm_pkg::REG_STAT: next_clr = avs_writedata_i[lpm_pkg::STAT_POE_BIT]
            & be_mask[lpm_pkg::STAT_POE_BIT];
        lpm_pkg::REG_WMASK: next_wmask = (rd_mux[IRQ_W-1:0] & ~be_mask[IRQ_W-1:0])
            | (avs_writedata_i[IRQ_W-1:0] & be_mask[IRQ_W-1:0]);
        default: next_clr = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
      ctrl_o <= lpm_pkg::lpm_ctrl_t'(lpm_pkg::CTRL_RST);
      wmask_o <= lpm_pkg::WMASK_RST[IRQ_W-1:0];
      poe_clr_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= next_wait;
      avs_readdata_o <= next_rdata;
      ctrl_o <= next_ctrl;
      wmask_o <= next_wmask;
      poe_clr_o <= next_clr;
    end
  end
endmodule : lpm_regs
`default_nettype wire

// >>> lpm_ctrl_tb.sv
// Self-checking testbench of the low-power mode controller
`default_nettype none
module lpm_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ********************************
  // Signals and design
  // ********************************
  localparam int OSC_N = 2;
  localparam int PLL_N = 2;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic wait_exec_i = 1'b0;
  logic [7:0] irq_i = 8'h00;
  logic poe_irq_i = 1'b0;
  logic wake_int_o;
  logic wake_reset_o;
  logic poe_irq_o;
  lpm_pkg::lpm_dom_t dom_o;
  logic io_hold_o;
  logic [31:0] rd;
  int fail_count = 0;
  int checks_done = 0;

  lpm_ctrl #(.IRQ_W(8), .CNT_W(8), .OSC_CYC(OSC_N), .PLL_CYC(PLL_N)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .wait_exec_i(wait_exec_i), .irq_i(irq_i),
    .poe_irq_i(poe_irq_i), .wake_int_o(wake_int_o), .wake_reset_o(wake_reset_o),
    .poe_irq_o(poe_irq_o), .dom_o(dom_o), .io_hold_o(io_hold_o)
  );

  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  // ********************************
  // Tasks
  // ********************************
  task automatic summarize;
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : cmp32

  task automatic cmp1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : cmp1

  // One Avalon access; entered right after a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rdat);
    int n;
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= wd;
    avs_byteenable_i <= be;
    n = 0;
    // Sample waitrequest and read data as they stood at the rising edge
    @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 50) begin
      n++;
      @(posedge mclk_i);
    end
    if (n >= 50) begin
      fail_count++;
      $display("Error at %0t: no bus answer", $time);
    end
    rdat = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, a, wd, 4'hF, dummy);
  endtask : wr

  task automatic chk_rd(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, a, 32'h00000000, 4'hF, got);
    cmp32(got & mask, exp);
  endtask : chk_rd

  // Program mode, execute wait, check sleep state
  task automatic enter(input logic [31:0] ctrl, input logic [7:0] mask);
    wr(lpm_pkg::REG_CTRL, ctrl);
    wr(lpm_pkg::REG_WMASK, {24'h000000, mask});
    wait_exec_i <= 1'b1;
    @(posedge mclk_i);
    wait_exec_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk_rd(lpm_pkg::REG_STAT, 32'h000000FF, {24'h000000, ctrl[1:0], 6'h04});
    #1;
    cmp1(dom_o.cpu_clk, 1'b0);
    cmp1(io_hold_o, 1'b1);
    cmp1(dom_o.por_en, 1'b1);
    @(posedge mclk_i);
  endtask : enter

  // Raise a wake source and time the restore order
  task automatic wake(input int idx, input logic exp_rst, input logic chk_order);
    int n;
    int n_osc;
    int n_pll;
    int n_cpu;
    n_osc = 0;
    n_pll = 0;
    n_cpu = 0;
    irq_i <= 8'h01 << idx;
    for (n = 1; n < 40; n++) begin
      @(posedge mclk_i);
      #1;
      if (n_osc == 0 && dom_o.hoco === 1'b1) n_osc = n;
      if (n_pll == 0 && dom_o.pll === 1'b1) n_pll = n;
      if (n_cpu == 0 && dom_o.cpu_clk === 1'b1) n_cpu = n;
      if (wake_int_o === 1'b1 || wake_reset_o === 1'b1) break;
    end
    cmp32(n, OSC_N + PLL_N + 1);
    cmp1(wake_int_o, ~exp_rst);
    cmp1(wake_reset_o, exp_rst);
    cmp1(io_hold_o, 1'b0);
    if (chk_order) begin
      cmp32(n_osc, 1);
      cmp32(n_pll, 1 + OSC_N);
      cmp32(n_cpu, n);
    end
    @(posedge mclk_i);
    irq_i <= 8'h00;
    repeat (2) @(posedge mclk_i);
    chk_rd(lpm_pkg::REG_STAT, 32'h0000003F, 32'h00000001);
  endtask : wake

  // ********************************
  // Tests
  // ********************************
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    cmp1(dom_o.hoco, 1'b1);
    cmp1(dom_o.loco, 1'b1);
    cmp1(dom_o.cpu_clk, 1'b1);
    @(posedge mclk_i);
    chk_rd(lpm_pkg::REG_CTRL, 32'hFFFFFFFF, 32'h00000030);
    chk_rd(lpm_pkg::REG_WMASK, 32'hFFFFFFFF, 32'h00000000);
    chk_rd(lpm_pkg::REG_STAT, 32'hFFFFFFFF, 32'h00000001);
    wr(4'hC, 32'hFFFFFFFF);
    chk_rd(4'hC, 32'hFFFFFFFF, 32'h00000000);
    bus(1'b1, lpm_pkg::REG_CTRL, 32'hFFFFFFFF, 4'h2, rd);
    chk_rd(lpm_pkg::REG_CTRL, 32'hFFFFFFFF, 32'h00007F30);
    // Wait with mode none is ignored
    wr(lpm_pkg::REG_CTRL, 32'h00001FFC);
    wait_exec_i <= 1'b1;
    @(posedge mclk_i);
    wait_exec_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk_rd(lpm_pkg::REG_STAT, 32'h0000003F, 32'h00000001);
    // Clock stop: modules run per control, port disable never wakes
    enter(32'h00001FFD, 8'h01);
    cmp1(dom_o.ram_clk, 1'b0);
    cmp1(dom_o.usb_clk, 1'b0);
    cmp1(dom_o.tmr_clk, 1'b1);
    cmp1(dom_o.poe_clk, 1'b1);
    cmp1(dom_o.independent_watchdog_clk, 1'b1);
    cmp1(dom_o.hoco, 1'b1);
    cmp1(dom_o.ram_pwr_off, 1'b0);
    poe_irq_i <= 1'b1;
    irq_i <= 8'h02;
    repeat (2) @(posedge mclk_i);
    poe_irq_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    #1;
    cmp1(dom_o.cpu_clk, 1'b0);
    cmp1(poe_irq_o, 1'b0);
    @(posedge mclk_i);
    irq_i <= 8'h00;
    chk_rd(lpm_pkg::REG_STAT, 32'h000001FF, 32'h00000144);
    wake(0, 1'b0, 1'b0);
    #1;
    cmp1(poe_irq_o, 1'b1);
    @(posedge mclk_i);
    wr(lpm_pkg::REG_STAT, 32'h00000100);
    chk_rd(lpm_pkg::REG_STAT, 32'h0000013F, 32'h00000001);
    #1;
    cmp1(poe_irq_o, 1'b0);
    @(posedge mclk_i);
    // Software standby: internal clocks off, timers frozen
    enter(32'h00001FFE, 8'h04);
    cmp1(dom_o.hoco, 1'b0);
    cmp1(dom_o.loco, 1'b0);
    cmp1(dom_o.pll, 1'b0);
    cmp1(dom_o.peripheral_pll, 1'b0);
    cmp1(dom_o.main_osc, 1'b1);
    cmp1(dom_o.tmr_clk, 1'b0);
    cmp1(dom_o.poe_clk, 1'b0);
    cmp1(dom_o.tmr_pwr_off, 1'b0);
    cmp1(dom_o.independent_watchdog_clk, 1'b1);
    cmp1(dom_o.ram_pwr_off, 1'b0);
    cmp1(dom_o.lvd_en, 1'b1);
    wake(2, 1'b0, 1'b1);
    // Deep standby: power removed, resume through reset
    enter(32'h00001FFF, 8'h80);
    cmp1(dom_o.ram_pwr_off, 1'b1);
    cmp1(dom_o.independent_watchdog_pwr_off, 1'b1);
    cmp1(dom_o.independent_watchdog_osc, 1'b0);
    cmp1(dom_o.tmr_pwr_off, 1'b1);
    cmp1(dom_o.poe_pwr_off, 1'b1);
    cmp1(dom_o.usb_pwr_off, 1'b1);
    cmp1(dom_o.rtc_en, 1'b1);
    cmp1(dom_o.lvd_en, 1'b1);
    wake(7, 1'b1, 1'b1);
    enter(32'h00007CFF, 8'h10);
    cmp1(dom_o.usb_pwr_off, 1'b0);
    cmp1(dom_o.lvd_en, 1'b0);
    cmp1(dom_o.rtc_en, 1'b0);
    wake(4, 1'b1, 1'b1);
    summarize();
  end

  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule : lpm_ctrl_tb
`default_nettype wire
